/* File: hw/mfc_level_ctr.sv */
// Purpose: occupancy counter for one fifo, add and subtract per cycle
// Assumes: amounts never drive the level past its range
// Notes: flush returns the level to its reset value and wins over counting
`timescale 1ns/1ns

module mfc_level_ctr #(
   parameter int WIDTH = 16,
   parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // control
   input wire logic flush,
   input wire logic [WIDTH-1:0] incAmt,
   input wire logic [WIDTH-1:0] decAmt,
   // state
   output logic [WIDTH-1:0] level
);

   always_ff @(posedge clk) begin
      if (!rst_n || flush) begin
         level <= RESET_VALUE;
      end else begin
         level <= level + incAmt - decAmt;
      end
   end

endmodule

/* File: hw/mfc_pkg.sv */
// Purpose: constants for the MAC FIFO control and status register bank
// Assumes: 32-bit AXI4-Lite register access, byte addresses as printed
// Notes: offsets, field positions, reset values and bus codes live here
//
// Operation
// - status flush empties tx status fifo
// - data flush empties tx data fifo
// - permit low: full status halts transmit
// - permit high: transmit continues when status full
// - status full flag ignores permit
// - enable set: send queued tx data
// - enable self-clears after requested halt
// - stop finishes current frame first
// - stop bit self-clears when halted
// - stop bit writes ignored while it reads one
// - skip advances rx data to next frame
// - skip bit high until skip completes
// - report rx status words used
// - report rx data bytes used
// - partial word frames round up
// - report tx status words used
// - report tx data bytes free

package mfc_pkg;

   // ************************************************************
   // bus and address map
   // ************************************************************
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] OFS_TRANSMIT_CONFIG = 8'h70;
   localparam logic [ADDR_W-1:0] OFS_RECEIVE_DATAPATH_CONTROL = 8'h78;
   localparam logic [ADDR_W-1:0] OFS_RECEIVE_FIFO_LEVELS = 8'h7C;
   localparam logic [ADDR_W-1:0] OFS_TRANSMIT_FIFO_LEVELS = 8'h80;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ************************************************************
   // field positions
   // ************************************************************
   localparam int TXC_STATUS_FLUSH = 15;
   localparam int TXC_DATA_FLUSH = 14;
   localparam int TXC_OVERRUN_PERMIT = 2;
   localparam int TXC_TX_ON = 1;
   localparam int TXC_STOP = 0;
   localparam int RXD_FRAME_SKIP = 31;
   localparam int LVL_WORDS_LSB = 16;
   localparam int LVL_WORDS_MSB = 23;
   localparam int LVL_BYTES_MSB = 15;

   // ************************************************************
   // widths and reset values
   // ************************************************************
   localparam int WORDS_W = 8;
   localparam int BYTES_W = 16;
   localparam logic [31:0] REG_RESET = 32'h0000_0000;
   localparam logic [BYTES_W-1:0] TX_DATA_CAPACITY = 16'h1200;
   localparam logic [WORDS_W-1:0] TX_STATUS_DEPTH = 8'h80;
   localparam logic [BYTES_W-1:0] WORD_ROUND_ADD = 16'h0003;
   localparam logic [BYTES_W-1:0] WORD_ROUND_MASK = 16'hFFFC;

endpackage

/* File: hw/mfc_regs.sv */
// Purpose: AXI4-Lite register bank for tx/rx fifo control and levels
// Assumes: fifo events arrive as one-cycle pulses on the same clock
// Notes: level counters sit in mfc_level_ctr, one instance per fifo
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ns

module mfc_regs #(
   parameter logic [mfc_pkg::WORDS_W-1:0] TX_STATUS_DEPTH = mfc_pkg::TX_STATUS_DEPTH,
   parameter logic [mfc_pkg::BYTES_W-1:0] TX_DATA_CAPACITY = mfc_pkg::TX_DATA_CAPACITY
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // axi4-lite write address
   input wire logic awvalid,
   output logic awready,
   input wire logic [mfc_pkg::ADDR_W-1:0] awaddr,
   input wire logic [2:0] awprot,
   // axi4-lite write data
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   // axi4-lite write response
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // axi4-lite read address
   input wire logic arvalid,
   output logic arready,
   input wire logic [mfc_pkg::ADDR_W-1:0] araddr,
   input wire logic [2:0] arprot,
   // axi4-lite read data
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   // transmitter
   input wire logic txFrameActive,
   output logic txRun,
   output logic txEnabled,
   // tx status fifo
   input wire logic txStatusPush,
   input wire logic txStatusPop,
   output logic txStatusFlush,
   output logic tx_status_full_irq,
   // tx data fifo
   input wire logic txDataPush,
   input wire logic [mfc_pkg::BYTES_W-1:0] txDataPushBytes,
   input wire logic txDataPop,
   input wire logic [mfc_pkg::BYTES_W-1:0] txDataPopBytes,
   output logic txDataFlush,
   // rx status fifo
   input wire logic rxStatusPush,
   input wire logic rxStatusPop,
   // rx data fifo
   input wire logic rxFrameDone,
   input wire logic [mfc_pkg::BYTES_W-1:0] rxFrameLen,
   input wire logic rxDataPop,
   input wire logic [mfc_pkg::BYTES_W-1:0] rxDataPopBytes,
   input wire logic rxSkipDone,
   output logic rxSkipReq
);
   import mfc_pkg::*;

   // ************************************************************
   // declarations
   // ************************************************************
   logic awHeld;
   logic wHeld;
   logic [ADDR_W-1:0] awAddrHeld;
   logic [31:0] wDataHeld;
   logic [3:0] wStrbHeld;
   logic writeFire;
   logic readFire;
   logic wrTxCfg;
   logic wrRxDp;
   logic wrMapped;
   logic rdMapped;
   logic [31:0] next_rdata;

   logic status_overrun_permit;
   logic txOn;
   logic stopTx;
   logic txHalted;
   logic rx_frame_skip;

   logic [WORDS_W-1:0] rx_status_words_used;
   logic [BYTES_W-1:0] rx_data_bytes_used;
   logic [WORDS_W-1:0] tx_status_words_used;
   logic [BYTES_W-1:0] tx_data_bytes_free;
   logic [WORDS_W-1:0] txsInc;
   logic [WORDS_W-1:0] txsDec;
   logic [WORDS_W-1:0] rxsInc;
   logic [WORDS_W-1:0] rxsDec;
   logic [BYTES_W-1:0] rxdInc;
   logic [BYTES_W-1:0] rxdDec;
   logic [BYTES_W-1:0] txdInc;
   logic [BYTES_W-1:0] txdDec;
   logic txStatusFull;

   // ************************************************************
   // axi4-lite write channel
   // ************************************************************
   // address and data are taken in either order, then one response
   assign awready = !awHeld && !bvalid;
   assign wready = !wHeld && !bvalid;
   assign writeFire = awHeld && wHeld && !bvalid;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         awHeld <= 1'b0;
         awAddrHeld <= '0;
      end else if (awvalid && awready) begin
         awHeld <= 1'b1;
         awAddrHeld <= awaddr;
      end else if (writeFire) begin
         awHeld <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wHeld <= 1'b0;
         wDataHeld <= REG_RESET;
         wStrbHeld <= 4'h0;
      end else if (wvalid && wready) begin
         wHeld <= 1'b1;
         wDataHeld <= wdata;
         wStrbHeld <= wstrb;
      end else if (writeFire) begin
         wHeld <= 1'b0;
      end
   end

   assign wrTxCfg = writeFire && (awAddrHeld == OFS_TRANSMIT_CONFIG);
   assign wrRxDp = writeFire && (awAddrHeld == OFS_RECEIVE_DATAPATH_CONTROL);
   // level registers accept writes silently; unknown offsets get an error
   assign wrMapped = (awAddrHeld == OFS_TRANSMIT_CONFIG)
      || (awAddrHeld == OFS_RECEIVE_DATAPATH_CONTROL)
      || (awAddrHeld == OFS_RECEIVE_FIFO_LEVELS)
      || (awAddrHeld == OFS_TRANSMIT_FIFO_LEVELS);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
      end else if (writeFire) begin
         bvalid <= 1'b1;
         bresp <= wrMapped ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   // ************************************************************
   // axi4-lite read channel
   // ************************************************************
   assign arready = !rvalid;
   assign readFire = arvalid && arready;

   always_comb begin
      rdMapped = 1'b1;
      next_rdata = REG_RESET;
      unique case (araddr)
         OFS_TRANSMIT_CONFIG: begin
            // flush bits always read zero
            next_rdata[TXC_OVERRUN_PERMIT] = status_overrun_permit;
            next_rdata[TXC_TX_ON] = txOn;
            next_rdata[TXC_STOP] = stopTx;
         end
         OFS_RECEIVE_DATAPATH_CONTROL: begin
            next_rdata[RXD_FRAME_SKIP] = rx_frame_skip;
         end
         OFS_RECEIVE_FIFO_LEVELS: begin
            next_rdata[LVL_WORDS_MSB:LVL_WORDS_LSB] = rx_status_words_used;
            next_rdata[LVL_BYTES_MSB:0] = rx_data_bytes_used;
         end
         OFS_TRANSMIT_FIFO_LEVELS: begin
            next_rdata[LVL_WORDS_MSB:LVL_WORDS_LSB] = tx_status_words_used;
            next_rdata[LVL_BYTES_MSB:0] = tx_data_bytes_free;
         end
         default: begin
            rdMapped = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rvalid <= 1'b0;
         rdata <= REG_RESET;
         rresp <= RESP_OKAY;
      end else if (readFire) begin
         rvalid <= 1'b1;
         rdata <= next_rdata;
         rresp <= rdMapped ? RESP_OKAY : RESP_SLVERR;
      end else if (rready) begin
         rvalid <= 1'b0;
      end
   end

   // ************************************************************
   // transmit configuration
   // ************************************************************
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         status_overrun_permit <= 1'b0;
      end else if (wrTxCfg && wStrbHeld[0]) begin
         status_overrun_permit <= wDataHeld[TXC_OVERRUN_PERMIT];
      end
   end

   // halted: stop pending, start gate already closed, no frame on the wire
   assign txHalted = stopTx && !txRun && !txFrameActive;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         txOn <= 1'b0;
      end else if (txHalted) begin
         txOn <= 1'b0;
      end else if (wrTxCfg && wStrbHeld[0]) begin
         txOn <= wDataHeld[TXC_TX_ON];
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         stopTx <= 1'b0;
      end else if (stopTx) begin
         // writes cannot touch the bit while it is high
         if (txHalted) begin
            stopTx <= 1'b0;
         end
      end else if (wrTxCfg && wStrbHeld[0]) begin
         stopTx <= wDataHeld[TXC_STOP];
      end
   end

   // new frames may start only while enabled, not stopping, not blocked
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         txRun <= 1'b0;
      end else begin
         txRun <= txOn && !stopTx
            && (status_overrun_permit || !txStatusFull);
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         txEnabled <= 1'b0;
      end else begin
         txEnabled <= txOn;
      end
   end

   // ************************************************************
   // flush strobes
   // ************************************************************
   // write-only bits: they only produce a one-cycle pulse
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         txStatusFlush <= 1'b0;
         txDataFlush <= 1'b0;
      end else begin
         txStatusFlush <= wrTxCfg && wStrbHeld[1] && wDataHeld[TXC_STATUS_FLUSH];
         txDataFlush <= wrTxCfg && wStrbHeld[1] && wDataHeld[TXC_DATA_FLUSH];
      end
   end

   // ************************************************************
   // receive frame skip
   // ************************************************************
   // software should not read rx data while this reads one
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rx_frame_skip <= 1'b0;
      end else if (rx_frame_skip) begin
         if (rxSkipDone) begin
            rx_frame_skip <= 1'b0;
         end
      end else if (wrRxDp && wStrbHeld[3] && wDataHeld[RXD_FRAME_SKIP]) begin
         rx_frame_skip <= 1'b1;
      end
   end

   assign rxSkipReq = rx_frame_skip;

   // ************************************************************
   // occupancy counters
   // ************************************************************
   assign txsInc = {{(WORDS_W-1){1'b0}}, txStatusPush};
   assign txsDec = {{(WORDS_W-1){1'b0}}, txStatusPop};
   assign rxsInc = {{(WORDS_W-1){1'b0}}, rxStatusPush};
   assign rxsDec = {{(WORDS_W-1){1'b0}}, rxStatusPop};
   // partial final word counts as a whole word
   assign rxdInc = rxFrameDone ? ((rxFrameLen + WORD_ROUND_ADD) & WORD_ROUND_MASK) : '0;
   assign rxdDec = rxDataPop ? rxDataPopBytes : '0;
   // free space grows as the transmitter drains, shrinks as software fills
   assign txdInc = txDataPop ? txDataPopBytes : '0;
   assign txdDec = txDataPush ? txDataPushBytes : '0;

   mfc_level_ctr #(
      .WIDTH(WORDS_W),
      .RESET_VALUE('0)
   ) txStatusLevel (
      .clk(clk),
      .rst_n(rst_n),
      .flush(txStatusFlush),
      .incAmt(txsInc),
      .decAmt(txsDec),
      .level(tx_status_words_used)
   );

   mfc_level_ctr #(
      .WIDTH(BYTES_W),
      .RESET_VALUE(TX_DATA_CAPACITY)
   ) txDataLevel (
      .clk(clk),
      .rst_n(rst_n),
      .flush(txDataFlush),
      .incAmt(txdInc),
      .decAmt(txdDec),
      .level(tx_data_bytes_free)
   );

   mfc_level_ctr #(
      .WIDTH(WORDS_W),
      .RESET_VALUE('0)
   ) rxStatusLevel (
      .clk(clk),
      .rst_n(rst_n),
      .flush(1'b0),
      .incAmt(rxsInc),
      .decAmt(rxsDec),
      .level(rx_status_words_used)
   );

   mfc_level_ctr #(
      .WIDTH(BYTES_W),
      .RESET_VALUE('0)
   ) rxDataLevel (
      .clk(clk),
      .rst_n(rst_n),
      .flush(1'b0),
      .incAmt(rxdInc),
      .decAmt(rxdDec),
      .level(rx_data_bytes_used)
   );

   // ************************************************************
   // status fifo full flag
   // ************************************************************
   // full flag is built from the level alone, never from the permit bit
   assign txStatusFull = (tx_status_words_used == TX_STATUS_DEPTH);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         tx_status_full_irq <= 1'b0;
      end else begin
         tx_status_full_irq <= txStatusFull;
      end
   end

endmodule

/* File: sim/mfc_regs_bench.sv */
// Purpose: directed bench for the fifo control register bank
// Assumes: status depth shortened to four words
// Notes: bus inputs change on rising edges, outputs sampled on falling edges
`timescale 1ns/1ns

`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; \
   $display("CHECK FAILED %s expected %0h seen %0h", n, e, g); end end

module mfc_regs_bench;
   import mfc_pkg::*;
   logic clk = 0, rst_n = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic txFrameActive = 0, txStatusPush = 0, txDataPush = 0, rxStatusPush = 0;
   logic txStatusPop = 0, txDataPop = 0, rxStatusPop = 0;
   logic rxFrameDone = 0, rxDataPop = 0, rxSkipDone = 0;
   logic [7:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata, rdv;
   logic [3:0] wstrb = 0;
   logic [15:0] txDataPushBytes = 0, txDataPopBytes = 0, rxFrameLen = 0, rxDataPopBytes = 0;
   logic awready, wready, bvalid, arready, rvalid, txRun, txEnabled, txStatusFlush;
   logic tx_status_full_irq, txDataFlush, rxSkipReq;
   logic [1:0] bresp, rresp, br, rs;
   int fails = 0, num_checks = 0, statusFlushes = 0, dataFlushes = 0;

   always #2 clk = ~clk;

   // count flush pulses, each stands one whole cycle
   always @(negedge clk) begin
      if (txStatusFlush) statusFlushes++;
      if (txDataFlush) dataFlushes++;
   end

   mfc_regs #(.TX_STATUS_DEPTH(8'h04)) u_dut (.clk, .rst_n, .awvalid, .awready, .awaddr,
      .awprot(3'h0), .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid,
      .arready, .araddr, .arprot(3'h0), .rvalid, .rready, .rdata, .rresp, .txFrameActive,
      .txRun, .txEnabled, .txStatusPush, .txStatusPop, .txStatusFlush,
      .tx_status_full_irq, .txDataPush, .txDataPushBytes, .txDataPop,
      .txDataPopBytes, .txDataFlush, .rxStatusPush, .rxStatusPop,
      .rxFrameDone, .rxFrameLen, .rxDataPop, .rxDataPopBytes, .rxSkipDone, .rxSkipReq);

   // ************************************************************
   // bus tasks
   // ************************************************************
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
      logic ah, wh, bh;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      do begin
         @(negedge clk);
         ah = awvalid && awready;
         wh = wvalid && wready;
         bh = bvalid;
         br = bresp;
         @(posedge clk);
         if (ah) awvalid <= 0;
         if (wh) wvalid <= 0;
      end while (bh !== 1'b1);
      bready <= 0;
   endtask

   task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = RESP_OKAY);
      logic ah, rh;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      do begin
         @(negedge clk);
         ah = arvalid && arready;
         rh = rvalid;
         rdv = rdata;
         rs = rresp;
         @(posedge clk);
         if (ah) arvalid <= 0;
      end while (rh !== 1'b1);
      rready <= 0;
      `CHK("rdata", e, rdv)
      `CHK("rresp", er, rs)
   endtask

   task automatic at(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask

   task automatic summarize;
      if (fails == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   initial begin
      #40000;
      fails++;
      summarize();
   end

   // ************************************************************
   // tests
   // ************************************************************
   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1;
      rc(OFS_TRANSMIT_CONFIG, 32'h0);
      rc(OFS_RECEIVE_DATAPATH_CONTROL, 32'h0);
      rc(OFS_RECEIVE_FIFO_LEVELS, 32'h0);
      rc(OFS_TRANSMIT_FIFO_LEVELS, 32'h0000_1200);
      rc(8'h74, 32'h0, RESP_SLVERR);
      // fifo traffic, push stays below the free space
      @(posedge clk);
      {txStatusPush, rxStatusPush, rxFrameDone, txDataPush} <= 4'hF;
      rxFrameLen <= 16'h0005;
      txDataPushBytes <= 16'h0100;
      @(posedge clk);
      txDataPush <= 0;
      rxFrameLen <= 16'h0008;
      @(posedge clk);
      {rxFrameDone, rxStatusPush, rxDataPop} <= 3'h1;
      rxDataPopBytes <= 16'h0004;
      @(posedge clk);
      {txStatusPush, rxDataPop, txStatusPop, rxStatusPop, txDataPop} <= 5'h07;
      txDataPopBytes <= 16'h0040;
      @(posedge clk);
      {txStatusPop, rxStatusPop, txDataPop} <= 3'h0;
      rc(OFS_RECEIVE_FIFO_LEVELS, 32'h0001_000C);
      rc(OFS_TRANSMIT_FIFO_LEVELS, 32'h0002_1140);
      wr(OFS_TRANSMIT_CONFIG, 32'h0000_8000);
      rc(OFS_TRANSMIT_FIFO_LEVELS, 32'h0000_1140);
      `CHK("statusFlushes", 1, statusFlushes)
      rc(OFS_TRANSMIT_CONFIG, 32'h0);
      wr(OFS_TRANSMIT_CONFIG, 32'h0000_4000);
      rc(OFS_TRANSMIT_FIFO_LEVELS, 32'h0000_1200);
      `CHK("dataFlushes", 1, dataFlushes)
      `CHK("statusFlushes", 1, statusFlushes)
      wr(OFS_TRANSMIT_CONFIG, 32'h2, 4'hE);
      rc(OFS_TRANSMIT_CONFIG, 32'h0);
      // transmit enable and status-full suspension
      wr(OFS_TRANSMIT_CONFIG, 32'h2);
      at(2);
      `CHK("txRun", 1'b1, txRun)
      `CHK("txEnabled", 1'b1, txEnabled)
      @(posedge clk);
      txStatusPush <= 1;
      repeat (4) @(posedge clk);
      txStatusPush <= 0;
      at(2);
      `CHK("irq", 1'b1, tx_status_full_irq)
      `CHK("txRun", 1'b0, txRun)
      wr(OFS_TRANSMIT_CONFIG, 32'h6);
      at(2);
      `CHK("txRun", 1'b1, txRun)
      `CHK("irq", 1'b1, tx_status_full_irq)
      rc(OFS_TRANSMIT_FIFO_LEVELS, 32'h0004_1200);
      // stop during a frame
      @(posedge clk);
      txFrameActive <= 1;
      wr(OFS_TRANSMIT_CONFIG, 32'h7);
      at(2);
      `CHK("txRun", 1'b0, txRun)
      rc(OFS_TRANSMIT_CONFIG, 32'h7);
      wr(OFS_TRANSMIT_CONFIG, 32'h6);
      rc(OFS_TRANSMIT_CONFIG, 32'h7);
      @(posedge clk);
      txFrameActive <= 0;
      at(3);
      rc(OFS_TRANSMIT_CONFIG, 32'h4);
      `CHK("txEnabled", 1'b0, txEnabled)
      // frame skip, rx data left unread meanwhile
      wr(OFS_RECEIVE_DATAPATH_CONTROL, 32'h8000_0000);
      at(1);
      `CHK("rxSkipReq", 1'b1, rxSkipReq)
      wr(OFS_RECEIVE_DATAPATH_CONTROL, 32'h0);
      rc(OFS_RECEIVE_DATAPATH_CONTROL, 32'h8000_0000);
      @(posedge clk);
      rxSkipDone <= 1;
      @(posedge clk);
      rxSkipDone <= 0;
      at(2);
      `CHK("rxSkipReq", 1'b0, rxSkipReq)
      rc(OFS_RECEIVE_DATAPATH_CONTROL, 32'h0);
      // read-only and unmapped writes
      wr(OFS_TRANSMIT_FIFO_LEVELS, 32'hFFFF_FFFF);
      `CHK("bresp", RESP_OKAY, br)
      rc(OFS_TRANSMIT_FIFO_LEVELS, 32'h0004_1200);
      wr(8'h74, 32'h1);
      `CHK("bresp", RESP_SLVERR, br)
      summarize();
   end
endmodule

/* File: sim/mfc_regs_checker.sv */
// Purpose: port-level assertions for the fifo control register bank
// Assumes: one clock, synchronous active-low reset
// Notes: bound to mfc_regs after the module
`timescale 1ns/1ns

module mfc_regs_checker (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // register bus
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   // fifo side
   input wire logic txFrameActive,
   input wire logic txRun,
   input wire logic txEnabled,
   input wire logic txStatusFlush,
   input wire logic txDataFlush,
   input wire logic rxSkipDone,
   input wire logic rxSkipReq
);
   import mfc_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ************************************************************
   // assertions
   // ************************************************************
   sequence wrTaken;
      awvalid && awready && wvalid && wready;
   endsequence
   sequence wrAnswer;
      !awready ##[1:2] bvalid;
   endsequence
   chk_write_answer: assert property (wrTaken |=> wrAnswer)
      else $error("write response late");
   chk_read_answer: assert property (arvalid && arready |=> rvalid)
      else $error("read data late");
   chk_read_release: assert property (rvalid && rready |=> !rvalid && arready)
      else $error("read data not released");
   chk_slverr_zero: assert property (rvalid && rresp == RESP_SLVERR |-> rdata == 32'h0)
      else $error("error read carries data");
   chk_status_flush_pulse: assert property (txStatusFlush |=> !txStatusFlush)
      else $error("status flush not a pulse");
   chk_data_flush_pulse: assert property (txDataFlush |=> !txDataFlush)
      else $error("data flush not a pulse");
   chk_run_enabled: assert property (txRun |-> txEnabled)
      else $error("run without enable");
   chk_halt_after_frame: assert property ($fell(txEnabled) |-> !$past(txFrameActive, 2))
      else $error("halt inside a frame");
   chk_skip_holds: assert property (rxSkipReq && !rxSkipDone |=> rxSkipReq)
      else $error("skip dropped early");
   chk_skip_clears: assert property (rxSkipReq && rxSkipDone |=> !rxSkipReq)
      else $error("skip not cleared");
endmodule

bind mfc_regs mfc_regs_checker u_chk (.clk, .rst_n, .awvalid, .awready, .wvalid, .wready,
   .bvalid, .arvalid, .arready, .rvalid, .rready, .rdata, .rresp, .txFrameActive, .txRun,
   .txEnabled, .txStatusFlush, .txDataFlush, .rxSkipDone, .rxSkipReq);
